// ==== src/ddufc_pkg.sv ====
// Package for the dual channel converter update and format control block
package ddufc_pkg;

    // Register addresses within the register space
    localparam logic [7:0] ADDR_CODE_LOW  = 8'hD2;
    localparam logic [7:0] ADDR_CODE_HIGH = 8'hD3;
    localparam logic [7:0] ADDR_CONTROL   = 8'hD4;

    // Register pages for the two channels
    localparam logic [7:0] PAGE_CHAN0 = 8'h00;
    localparam logic [7:0] PAGE_CHAN1 = 8'h01;

    // Control field positions
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_MODE_HI    = 4;
    localparam int CTL_MODE_LO    = 3;
    localparam int CTL_FMT_HI     = 2;
    localparam int CTL_FMT_LO     = 0;

    // Writable control bits; bits 6 and 5 always read zero
    localparam logic [7:0] CTL_WRITE_MASK = 8'h9F;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [11:0] RST_CODE = 12'h000;

    // Update mode selection
    localparam logic [1:0] MODE_ON_HIGH_WRITE = 2'h0;
    localparam logic [1:0] MODE_TIMER3        = 2'h1;
    localparam logic [1:0] MODE_TIMER4        = 2'h2;
    localparam logic [1:0] MODE_TIMER2        = 2'h3;

    // Register bus request from the CPU core
    typedef struct packed {
        logic       wr;    // Write strobe
        logic       rd;    // Read strobe
        logic [7:0] addr;  // Register address
        logic [7:0] page;  // Register page
        logic [7:0] wdata; // Write data
    } ddufc_req_t;

    // Timer overflow pulses
    typedef struct packed {
        logic t2;  // Timer 2 overflow
        logic t3;  // Timer 3 overflow
        logic t4;  // Timer 4 overflow
    } ddufc_tmr_t;

    // Per channel register state
    typedef struct packed {
        logic [7:0]  low;   // Low data byte
        logic [7:0]  high;  // High data byte
        logic [7:0]  ctl;   // Control byte
        logic [11:0] code;  // Converter input latch
    } ddufc_chan_t;

    // Whole block state
    typedef struct packed {
        ddufc_chan_t [1:0] ch;    // Both channels
        logic [7:0]        rdata; // Read data
        logic              ren;   // Read data valid
    } ddufc_state_t;

endpackage

// ==== src/ddufc_top.sv ====
// Dual channel converter update, scheduling and justification control
`timescale 1ns/10ps
module ddufc_top
(
    input  wire logic                ref_clk,     // System clock 20 MHz
    input  wire logic                resetn,      // Async reset, active low
    input  wire ddufc_pkg::ddufc_req_t req,       // Register bus request
    input  wire ddufc_pkg::ddufc_tmr_t tmr,       // Timer overflow pulses
    output logic [7:0]               rdata,       // Read data
    output logic                     rdata_valid, // Read data valid
    output logic [11:0]              chan0_code,  // Channel 0 latch
    output logic [11:0]              chan1_code,  // Channel 1 latch
    output logic                     chan0_enable,// Channel 0 active
    output logic                     chan1_enable // Channel 1 active
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Justify high and low bytes into a 12-bit code
    function automatic logic [11:0] justify(input logic [7:0] hi,
                                            input logic [7:0] lo,
                                            input logic [2:0] fmt);
        logic [11:0] w;
        w = 12'h000;
        if (fmt[2])
            w = {hi, lo[7:4]};
        else
            case (fmt[1:0])
                2'h0:    w = {hi[3:0], lo};
                2'h1:    w = {hi[4:0], lo[7:1]};
                2'h2:    w = {hi[5:0], lo[7:2]};
                default: w = {hi[6:0], lo[7:3]};
            endcase
        return w;
    endfunction

    // Pick the overflow pulse of the selected timer
    function automatic logic tmr_sel(input logic [1:0] md,
                                     input ddufc_pkg::ddufc_tmr_t t);
        logic s;
        s = 1'b0;
        case (md)
            ddufc_pkg::MODE_TIMER3: s = t.t3;
            ddufc_pkg::MODE_TIMER4: s = t.t4;
            ddufc_pkg::MODE_TIMER2: s = t.t2;
            default:                s = 1'b0;
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    ddufc_pkg::ddufc_state_t state_reg;   // Registered state
    ddufc_pkg::ddufc_state_t state_next;  // Next state

    ////////////////////////////////////////////////////////////////////////
    // Next state logic

    // Register writes, reads and latch updates for both channels
    always_comb
    begin
        logic        sel;
        logic        hi_wr;
        logic [1:0]  md;
        logic [7:0]  nlow;
        logic [7:0]  nhigh;
        sel        = 1'b0;
        hi_wr      = 1'b0;
        md         = 2'h0;
        nlow       = 8'h00;
        nhigh      = 8'h00;
        state_next = state_reg;
        state_next.ren   = req.rd;
        state_next.rdata = 8'h00;
        for (int i = 0; i < 2; i++)
        begin
            // Page select per channel
            sel = (req.page == ((i == 0) ? ddufc_pkg::PAGE_CHAN0
                                         : ddufc_pkg::PAGE_CHAN1));
            md  = state_reg.ch[i].ctl[ddufc_pkg::CTL_MODE_HI:
                                      ddufc_pkg::CTL_MODE_LO];
            nlow  = state_reg.ch[i].low;
            nhigh = state_reg.ch[i].high;
            hi_wr = 1'b0;
            if (sel && req.wr)
            begin
                case (req.addr)
                    ddufc_pkg::ADDR_CODE_LOW:
                        nlow = req.wdata;
                    ddufc_pkg::ADDR_CODE_HIGH:
                    begin
                        nhigh = req.wdata;
                        hi_wr = 1'b1;
                    end
                    ddufc_pkg::ADDR_CONTROL:
                        state_next.ch[i].ctl =
                            req.wdata & ddufc_pkg::CTL_WRITE_MASK;
                    default: ;
                endcase
            end
            state_next.ch[i].low  = nlow;
            state_next.ch[i].high = nhigh;
            // Latch update; low byte write alone holds
            if (md == ddufc_pkg::MODE_ON_HIGH_WRITE)
            begin
                if (hi_wr)
                    state_next.ch[i].code =
                        justify(nhigh, nlow, state_reg.ch[i].ctl[2:0]);
            end
            else if (tmr_sel(md, tmr))
                state_next.ch[i].code =
                    justify(state_reg.ch[i].high, state_reg.ch[i].low,
                            state_reg.ch[i].ctl[2:0]);
            // Read mux
            if (sel && req.rd)
            begin
                case (req.addr)
                    ddufc_pkg::ADDR_CODE_LOW:
                        state_next.rdata = state_reg.ch[i].low;
                    ddufc_pkg::ADDR_CODE_HIGH:
                        state_next.rdata = state_reg.ch[i].high;
                    ddufc_pkg::ADDR_CONTROL:
                        state_next.rdata = state_reg.ch[i].ctl;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Registers all state; reset clears everything
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // All outputs come straight from state flops
    assign rdata        = state_reg.rdata;
    assign rdata_valid  = state_reg.ren;
    assign chan0_code   = state_reg.ch[0].code;
    assign chan1_code   = state_reg.ch[1].code;
    assign chan0_enable = state_reg.ch[0].ctl[ddufc_pkg::CTL_ENABLE_BIT];
    assign chan1_enable = state_reg.ch[1].ctl[ddufc_pkg::CTL_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // Control bits six and five never set
    property p_unused_zero;
        @(posedge ref_clk) disable iff (!resetn)
        state_reg.ch[0].ctl[6:5] == 2'h0 && state_reg.ch[1].ctl[6:5] == 2'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused control bits set");

    // Enable follows control write of channel 0
    property p_enable;
        @(posedge ref_clk) disable iff (!resetn)
        (req.wr && req.page == ddufc_pkg::PAGE_CHAN0 &&
         req.addr == ddufc_pkg::ADDR_CONTROL)
        |=> chan0_enable == $past(req.wdata[7]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable not taken from write");

    // High write in mode 00 updates latch with format
    property p_high_write;
        @(posedge ref_clk) disable iff (!resetn)
        (req.wr && req.page == ddufc_pkg::PAGE_CHAN0 &&
         req.addr == ddufc_pkg::ADDR_CODE_HIGH &&
         state_reg.ch[0].ctl[4:3] == 2'h0 && state_reg.ch[0].ctl[2:0] == 3'h0)
        |=> chan0_code == {state_reg.ch[0].high[3:0], state_reg.ch[0].low};
    endproperty
    a_high_write: assert property (p_high_write)
        else $error("on-demand latch wrong");

    // Low write alone never moves latch
    property p_low_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (req.wr && req.addr == ddufc_pkg::ADDR_CODE_LOW &&
         state_reg.ch[1].ctl[4:3] == 2'h0)
        |=> $stable(chan1_code);
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low write moved latch");

    // Timer 3 pulse in mode 01 copies bytes, format 1xx
    property p_t3;
        @(posedge ref_clk) disable iff (!resetn)
        (tmr.t3 && state_reg.ch[0].ctl[4:3] == 2'h1 && state_reg.ch[0].ctl[2])
        |=> chan0_code == {$past(state_reg.ch[0].high),
                           $past(state_reg.ch[0].low[7:4])};
    endproperty
    a_t3: assert property (p_t3)
        else $error("timer 3 update wrong");

    // Timer 4 pulse in mode 10, format 001
    property p_t4;
        @(posedge ref_clk) disable iff (!resetn)
        (tmr.t4 && state_reg.ch[1].ctl[4:3] == 2'h2 &&
         state_reg.ch[1].ctl[2:0] == 3'h1)
        |=> chan1_code == {$past(state_reg.ch[1].high[4:0]),
                           $past(state_reg.ch[1].low[7:1])};
    endproperty
    a_t4: assert property (p_t4)
        else $error("timer 4 update wrong");

    // Timer 2 pulse in mode 11, format 010
    property p_t2;
        @(posedge ref_clk) disable iff (!resetn)
        (tmr.t2 && state_reg.ch[0].ctl[4:3] == 2'h3 &&
         state_reg.ch[0].ctl[2:0] == 3'h2)
        |=> chan0_code == {$past(state_reg.ch[0].high[5:0]),
                           $past(state_reg.ch[0].low[7:2])};
    endproperty
    a_t2: assert property (p_t2)
        else $error("timer 2 update wrong");

    // Unselected timer never moves latch
    property p_unselected;
        @(posedge ref_clk) disable iff (!resetn)
        (state_reg.ch[0].ctl[4:3] == 2'h1 && !tmr.t3)
        |=> $stable(chan0_code);
    endproperty
    a_unselected: assert property (p_unselected)
        else $error("unselected timer updated");

    // Low byte write to channel 1 is stored in its register
    property p_low_rw;
        @(posedge ref_clk) disable iff (!resetn)
        (req.wr && req.page == ddufc_pkg::PAGE_CHAN1 &&
         req.addr == ddufc_pkg::ADDR_CODE_LOW)
        |=> state_reg.ch[1].low == $past(req.wdata);
    endproperty
    a_low_rw: assert property (p_low_rw)
        else $error("low byte not stored");

    // Main scenarios
    c_t3: cover property (@(posedge ref_clk) disable iff (!resetn)
        tmr.t3 && state_reg.ch[0].ctl[4:3] == 2'h1);
    c_hw: cover property (@(posedge ref_clk) disable iff (!resetn)
        req.wr && req.addr == ddufc_pkg::ADDR_CODE_HIGH);
    c_en: cover property (@(posedge ref_clk) disable iff (!resetn)
        chan1_enable);

endmodule // ddufc_top

// ==== tb/ddufc_cpu_model.sv ====
// CPU core model driving the register bus of the converter control block
`timescale 1ns/10ps
module ddufc_cpu_model
(
    input  wire logic            ref_clk, // System clock
    output ddufc_pkg::ddufc_req_t req     // Register bus request
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial req = '0;

    // One bus cycle: held up to the sampling edge, then released
    task automatic access(input logic w, input logic [7:0] page,
                          input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        req.wr    <= w;
        req.rd    <= ~w;
        req.page  <= page;
        req.addr  <= addr;
        req.wdata <= data;
        @(posedge ref_clk);
        req.wr    <= 1'b0;
        req.rd    <= 1'b0;
        // Released lines show the inverse, never the last value
        req.page  <= ~page;
        req.addr  <= ~addr;
        req.wdata <= ~data;
    endtask
endmodule // ddufc_cpu_model

// ==== tb/tb.sv ====
// Self-checking testbench of the converter update and format control
`timescale 1ns/10ps
module tb;
    logic                  ref_clk;     // System clock
    logic                  resetn;      // Reset, active low
    ddufc_pkg::ddufc_req_t req;         // Bus request from model
    ddufc_pkg::ddufc_tmr_t tmr;         // Timer pulses
    logic [7:0]            rdata;       // Read data
    logic                  rdata_valid; // Read data valid
    logic [11:0]           chan0_code;  // Channel 0 latch
    logic [11:0]           chan1_code;  // Channel 1 latch
    logic                  chan0_enable;// Channel 0 active
    logic                  chan1_enable;// Channel 1 active
    int                    miscompares; // Mismatch count
    int                    num_checks;  // Comparison count
    int                    seed;        // Random seed
    logic [7:0]            exp_q[$];    // Expected read data
    logic [11:0]           exp_code[2]; // Expected latches
    logic [7:0]            lo, hi, ctl; // Stimulus bytes
    logic [2:0]            tsel;        // Selected timer pulse
    logic [2:0]            fmt;         // Format field

    ////////////////////////////////////////////////////////////////////////
    // Clock and instances
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    ddufc_cpu_model cpu (.ref_clk(ref_clk), .req(req));
    ddufc_top dut (.ref_clk(ref_clk), .resetn(resetn), .req(req),
        .tmr(tmr), .rdata(rdata), .rdata_valid(rdata_valid),
        .chan0_code(chan0_code), .chan1_code(chan1_code),
        .chan0_enable(chan0_enable), .chan1_enable(chan1_enable));

    ////////////////////////////////////////////////////////////////////////
    // Comparison, reporting and helpers
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Justification worked out independently
    function automatic logic [11:0] just(logic [7:0] h, logic [7:0] l,
                                         logic [2:0] f);
        if (f[2]) return {h, l[7:4]};
        case (f[1:0])
            2'h0: return {h[3:0], l};
            2'h1: return {h[4:0], l[7:1]};
            2'h2: return {h[5:0], l[7:2]};
            default: return {h[6:0], l[7:3]};
        endcase
    endfunction
    task automatic rd(input logic [7:0] page, input logic [7:0] addr,
                      input logic [7:0] exp);
        exp_q.push_back(exp);
        cpu.access(1'b0, page, addr, 8'h00);
    endtask
    task automatic check_codes;
        @(negedge ref_clk);
        check(chan0_code, exp_code[0]);
        check(chan1_code, exp_code[1]);
    endtask
    task automatic pulse(input logic [2:0] v);
        @(posedge ref_clk);
        tmr <= v;
        @(posedge ref_clk);
        tmr <= '0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read monitor takes the oldest note on each valid
    always @(negedge ref_clk)
        if (rdata_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                miscompares++;
                $display("MISMATCH at %0t: read data not requested", $time);
            end
            else
                check({4'h0, rdata}, {4'h0, exp_q.pop_front()});
        end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 90016;
        resetn = 1'b0;
        tmr = '0;
        miscompares = 0;
        num_checks = 0;
        exp_code[0] = 12'h000;
        exp_code[1] = 12'h000;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        // Reset values, unmapped address and page
        for (int p = 0; p < 2; p++)
            for (int a = 2; a < 5; a++)
                rd(8'(p), 8'hD0 + 8'(a), 8'h00);
        rd(8'h00, 8'hD5, 8'h00);
        cpu.access(1'b1, 8'h02, ddufc_pkg::ADDR_CODE_HIGH, 8'hFF);
        check_codes();
        // On-demand updates in every format, both channels
        for (int p = 0; p < 2; p++)
            for (int f = 0; f < 8; f++)
            begin
                lo = 8'($random(seed));
                hi = 8'($random(seed));
                ctl = {1'b1, 2'($random(seed)), 2'b00, 3'(f)};
                cpu.access(1'b1, 8'(p), ddufc_pkg::ADDR_CONTROL, ctl);
                rd(8'(p), ddufc_pkg::ADDR_CONTROL, ctl & 8'h9F);
                cpu.access(1'b1, 8'(p), ddufc_pkg::ADDR_CODE_LOW, lo);
                check_codes();
                rd(8'(p), ddufc_pkg::ADDR_CODE_LOW, lo);
                cpu.access(1'b1, 8'(p), ddufc_pkg::ADDR_CODE_HIGH, hi);
                exp_code[p] = just(hi, lo, 3'(f));
                check_codes();
                check({11'h0, p ? chan1_enable : chan0_enable}, 12'h001);
            end
        // Timer scheduled updates, wrong timers first
        for (int p = 0; p < 2; p++)
            for (int m = 1; m < 4; m++)
            begin
                lo = 8'($random(seed));
                hi = 8'($random(seed));
                fmt = 3'($random(seed));
                tsel = (m == 1) ? 3'b010 : (m == 2) ? 3'b001 : 3'b100;
                ctl = {1'b1, 2'b00, 2'(m), fmt};
                cpu.access(1'b1, 8'(p), ddufc_pkg::ADDR_CONTROL, ctl);
                cpu.access(1'b1, 8'(p), ddufc_pkg::ADDR_CODE_LOW, lo);
                cpu.access(1'b1, 8'(p), ddufc_pkg::ADDR_CODE_HIGH, hi);
                check_codes();
                pulse(~tsel);
                check_codes();
                pulse(tsel);
                exp_code[p] = just(hi, lo, fmt);
                check_codes();
            end
        // Full scale and zero, then channel 0 disabled
        for (int v = 0; v < 2; v++)
        begin
            cpu.access(1'b1, 8'h00, ddufc_pkg::ADDR_CONTROL, 8'h84);
            cpu.access(1'b1, 8'h00, ddufc_pkg::ADDR_CODE_LOW, v ? 8'h00 : 8'hFF);
            cpu.access(1'b1, 8'h00, ddufc_pkg::ADDR_CODE_HIGH, v ? 8'h00 : 8'hFF);
            exp_code[0] = v ? 12'h000 : 12'hFFF;
            check_codes();
        end
        cpu.access(1'b1, 8'h00, ddufc_pkg::ADDR_CONTROL, 8'h00);
        @(negedge ref_clk);
        check({11'h0, chan0_enable}, 12'h000);
        // Drain outstanding reads under a bound
        for (int i = 0; i < 10 && exp_q.size() != 0; i++)
            @(posedge ref_clk);
        if (exp_q.size() != 0)
        begin
            miscompares++;
            $display("MISMATCH at %0t: reads left unanswered", $time);
        end
        end_sim();
    end
endmodule // tb
